// ==== design/e1_crc4_cas_multiframer.sv ====
// Purpose: E1 CRC-4 and CAS multiframing for transmit and receive time slot streams.
// Assumes: tsStrobe/tsNum mark each time slot on both directions, rxBasicAligned from framer.
// Notes:   Long timers are parameters so simulation can shorten them.
`timescale 1ns/1ps

// Function
// - CRC multiframe is sixteen frames, 2 ms.
// - Multiframe alignment pattern 001011 in NFAS bit one.
// - Two submultiframes of eight frames each.
// - CRC-4 over each transmit submultiframe, X^4+X+1.
// - Remainder goes in next submultiframe FAS bits.
// - Check received remainder against next submultiframe.
// - Over 914 errors per 1000 forces reframe.
// - E1/E2 low report submultiframe CRC errors.
// - Interworking disable bit clear selects automatic interworking.
// - Disabled interworking, 400 ms failure holds RAI high.
// - E-bits follow default bit while not synchronised.
// - Interworking: flicker, then non-CRC mode, RAI low.
// - Auto-disable holds RAI at force bit.
// - Disabled interworking: flicker, then RAI high, searching.
// - Sync ends search and drives RAI low.
// - CAS multiframe tracked independently, sixteen frames.
// - CAS alignment 0000 in slot 16 upper nibble.
// - Y bit zero when receive CAS aligned.
// - Spare bits 5, 7, 8 sent as one.
// - Frame n carries channels n and n+15.
// - Bit two zero marks FAS, one NFAS.
// - FAS carries 0011011 after bit one.
// - NFAS bit three carries remote alarm.
module e1_crc4_cas_multiframer
   import e1_mf_pkg::*;
#(
   parameter int reframeCycles = REFRAME_CYCLES,
   parameter int searchCycles  = SEARCH_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [8:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        tsStrobe,
   input  wire logic [4:0]  tsNum,
   input  wire logic [7:0]  txPayload,
   input  wire logic [7:0]  rxByte,
   input  wire logic        rxBasicAligned,
   output logic      [7:0]  txByte,
   output logic             txRai,
   output logic             reframeReq,
   output logic             crcErr,
   output logic             crcMfSyncStatus,
   output logic             casMfAligned,
   output logic             nonCrcMode
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   typedef struct packed {
      mf_state_t              mfState;
      logic [TIMER_W-1:0]     timer;
      logic [TIMER_W-1:0]     refrTimer;
      logic                   raiFlick;
      logic                   raiQ;
      logic [3:0]             txFrame;
      logic [3:0]             txCasFrame;
      logic [3:0]             txCrc;
      logic [3:0]             txRem;
      logic [7:0]             txByte;
      logic                   ebit1;
      logic                   ebit2;
      logic [3:0]             rxFrame;
      logic [3:0]             rxCasFrame;
      logic                   casAligned;
      logic [5:0]             mfHist;
      logic [3:0]             rxCrc;
      logic [3:0]             rxRem;
      logic                   remValid;
      logic [3:0]             rxCbits;
      logic [9:0]             checkCnt;
      logic [9:0]             errCnt;
      logic [9:0]             lastErrCnt;
      logic                   reframe;
      logic                   crcErr;
      logic [3:0]             ctrl;
      logic [CH_COUNT-1:0][3:0] txSig;
      logic [CH_COUNT-1:0][3:0] rxSig;
      logic                   ack;
      logic [31:0]            datOut;
   } state_t;

   state_t st_reg;
   state_t st_next;

   logic       raiOut;
   logic       ebitOut1;
   logic       ebitOut2;
   logic       txBit1;
   logic [7:0] txSel;
   logic [7:0] crcIn;
   logic [3:0] txCrcNew;
   logic [3:0] rxCrcNew;
   logic [5:0] histNew;
   logic       mfMatch;
   logic       mfBad;
   logic       err;
   logic       wbReq;
   logic [6:0] wbWord;
   logic [6:0] txIdx;
   logic [6:0] rxIdx;
   logic [4:0] sigHi;
   logic [4:0] sigLo;
   logic [4:0] rxHi;
   logic [4:0] rxLo;

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.reframe = 1'b0;
      st_next.crcErr = 1'b0;
      err = 1'b0;
      mfMatch = 1'b0;
      mfBad = 1'b0;
      histNew = st_reg.mfHist;
      // Remote alarm selection.
      if (st_reg.ctrl[CTRL_RAD]) begin
         raiOut = st_reg.ctrl[CTRL_RAF];
      end else begin
         case (st_reg.mfState)
            MF_SYNC:   raiOut = 1'b0;
            MF_SEARCH: raiOut = st_reg.raiFlick;
            MF_ALARM:  raiOut = 1'b1;
            MF_NONCRC: raiOut = 1'b0;
            default:   raiOut = 1'b1;
         endcase
      end
      st_next.raiQ = raiOut;
      // E-bits follow the default bit whenever the multiframe is not in sync.
      ebitOut1 = (st_reg.mfState == MF_SYNC) ? st_reg.ebit1 : st_reg.ctrl[CTRL_EDEF];
      ebitOut2 = (st_reg.mfState == MF_SYNC) ? st_reg.ebit2 : st_reg.ctrl[CTRL_EDEF];
      // Transmit time slot zero bit one: remainder, MFAS or E-bit.
      if (!st_reg.txFrame[0]) begin
         txBit1 = st_reg.txRem[CBIT_TOP - st_reg.txFrame[2:1]];
      end else if (st_reg.txFrame <= FRAME_MFAS_END) begin
         txBit1 = MFAS_PATTERN[MFAS_TOP - st_reg.txFrame[3:1]];
      end else if (st_reg.txFrame == FRAME_E1) begin
         txBit1 = ebitOut1;
      end else begin
         txBit1 = ebitOut2;
      end
      sigHi = {1'b0, st_reg.txCasFrame} - SIG_HI_OFS;
      sigLo = {1'b0, st_reg.txCasFrame} + SIG_LO_OFS;
      case (tsNum)
         TS_ALIGN: begin
            if (!st_reg.txFrame[0]) begin
               txSel = {txBit1, FAS_PATTERN};
            end else begin
               txSel = {txBit1, 1'b1, raiOut, SA_IDLE};
            end
         end
         TS_SIG: begin
            if (st_reg.txCasFrame == FRAME_CAS0) begin
               // Y bit in bit 6, spare X bits in 5, 7 and 8.
               txSel = {CAS_MFAS, SPARE_BIT, !st_reg.casAligned,
                        SPARE_BIT, SPARE_BIT};
            end else begin
               txSel = {st_reg.txSig[sigHi], st_reg.txSig[sigLo]};
            end
         end
         default: txSel = txPayload;
      endcase
      // Remainder bit positions enter the CRC as zero.
      crcIn = ((tsNum == TS_ALIGN) && !st_reg.txFrame[0]) ? {1'b0, txSel[6:0]} : txSel;
      txCrcNew = crc4_byte(st_reg.txCrc, crcIn);

      // ------------------------------------------------------------------
      // Transmit side
      // ------------------------------------------------------------------
      if (tsStrobe) begin
         st_next.txByte = txSel;
         st_next.txCrc = txCrcNew;
         if ((tsNum == TS_ALIGN) && st_reg.txFrame[0]) begin
            st_next.raiFlick = 1'b0;
         end
         if (tsNum == TS_LAST) begin
            st_next.txFrame = st_reg.txFrame + 4'h1;
            st_next.txCasFrame = st_reg.txCasFrame + 4'h1;
            if (st_reg.txFrame[2:0] == SMF_LAST) begin
               st_next.txRem = txCrcNew;
               st_next.txCrc = 4'h0;
            end
         end
      end

      // ------------------------------------------------------------------
      // Receive side
      // ------------------------------------------------------------------
      rxHi = {1'b0, st_reg.rxCasFrame} - SIG_HI_OFS;
      rxLo = {1'b0, st_reg.rxCasFrame} + SIG_LO_OFS;
      rxCrcNew = crc4_byte(st_reg.rxCrc, ((tsNum == TS_ALIGN) && !rxByte[6]) ?
                           {1'b0, rxByte[6:0]} : rxByte);
      if (tsStrobe && rxBasicAligned) begin
         st_next.rxCrc = rxCrcNew;
         if (tsNum == TS_ALIGN) begin
            if (rxByte[6]) begin
               histNew = {st_reg.mfHist[4:0], rxByte[7]};
               st_next.mfHist = histNew;
               mfMatch = (histNew == MFAS_PATTERN);
               if (st_reg.rxFrame <= FRAME_MFAS_END) begin
                  mfBad = rxByte[7] != MFAS_PATTERN[MFAS_TOP - st_reg.rxFrame[3:1]];
               end
               if (mfMatch && (st_reg.mfState != MF_SYNC)) begin
                  st_next.rxFrame = FRAME_MFAS_END;
               end
            end else begin
               st_next.rxCbits = {st_reg.rxCbits[2:0], rxByte[7]};
            end
         end
         if (tsNum == TS_SIG) begin
            if (rxByte[7:4] == CAS_MFAS) begin
               st_next.casAligned = 1'b1;
               st_next.rxCasFrame = FRAME_CAS0;
            end else if (st_reg.rxCasFrame == FRAME_CAS0) begin
               st_next.casAligned = 1'b0;
            end else if (st_reg.casAligned) begin
               st_next.rxSig[rxHi] = rxByte[7:4];
               st_next.rxSig[rxLo] = rxByte[3:0];
            end
         end
         if (tsNum == TS_LAST) begin
            st_next.rxFrame = st_reg.rxFrame + 4'h1;
            st_next.rxCasFrame = st_reg.rxCasFrame + 4'h1;
            if (st_reg.rxFrame[2:0] == SMF_LAST) begin
               st_next.rxCrc = 4'h0;
               st_next.rxRem = rxCrcNew;
               st_next.remValid = (st_reg.mfState == MF_SYNC) &&
                                  (st_reg.remValid || (st_reg.rxFrame == FRAME_SMF1END));
               if ((st_reg.mfState == MF_SYNC) && st_reg.remValid) begin
                  err = st_reg.rxCbits != st_reg.rxRem;
                  st_next.crcErr = err;
                  // End of submultiframe 1 closes the check of submultiframe 2.
                  if (st_reg.rxFrame == FRAME_SMF1END) begin
                     st_next.ebit2 = !err;
                  end else begin
                     st_next.ebit1 = !err;
                  end
                  st_next.errCnt = st_reg.errCnt + {9'h000, err};
                  st_next.checkCnt = st_reg.checkCnt + 10'h001;
                  if (st_next.checkCnt == CHECKS_PER_SEC) begin
                     st_next.reframe = st_next.errCnt > ERR_LIMIT;
                     st_next.lastErrCnt = st_next.errCnt;
                     st_next.checkCnt = 10'h000;
                     st_next.errCnt = 10'h000;
                  end
               end
            end
         end
      end

      // ------------------------------------------------------------------
      // Multiframe alignment control
      // ------------------------------------------------------------------
      case (st_reg.mfState)
         MF_SEARCH: begin
            st_next.timer = st_reg.timer + 24'h000001;
            st_next.refrTimer = st_reg.refrTimer + 24'h000001;
            if (mfMatch) begin
               st_next.mfState = MF_SYNC;
            end else if (st_reg.timer == TIMER_W'(searchCycles - 1)) begin
               st_next.mfState = st_reg.ctrl[CTRL_IWD] ? MF_ALARM : MF_NONCRC;
            end else if (st_reg.refrTimer == TIMER_W'(reframeCycles - 1)) begin
               st_next.refrTimer = 24'h000000;
               st_next.reframe = 1'b1;
               st_next.raiFlick = 1'b1;
            end
         end
         MF_ALARM: begin
            if (mfMatch) begin
               st_next.mfState = MF_SYNC;
            end
         end
         MF_NONCRC: begin
            if (st_reg.ctrl[CTRL_IWD]) begin
               st_next.mfState = MF_SEARCH;
            end
         end
         MF_SYNC: begin
            if (!rxBasicAligned || mfBad) begin
               st_next.mfState = MF_SEARCH;
               st_next.remValid = 1'b0;
            end
         end
         default: st_next.mfState = MF_SEARCH;
      endcase
      if (st_next.mfState != st_reg.mfState) begin
         st_next.timer = 24'h000000;
         st_next.refrTimer = 24'h000000;
         st_next.checkCnt = 10'h000;
         st_next.errCnt = 10'h000;
         st_next.ebit1 = 1'b1;
         st_next.ebit2 = 1'b1;
      end

      // ------------------------------------------------------------------
      // Wishbone slave
      // ------------------------------------------------------------------
      wbReq = cyc_i && stb_i && !st_reg.ack;
      wbWord = adr_i[8:2];
      txIdx = wbWord - TXSIG_WORD;
      rxIdx = wbWord - RXSIG_WORD;
      st_next.ack = wbReq;
      if (wbReq) begin
         st_next.datOut = 32'h00000000;
         if (adr_i == REG_CTRL) begin
            st_next.datOut[3:0] = st_reg.ctrl;
            if (we_i && sel_i[0]) begin
               st_next.ctrl = dat_i[3:0];
            end
         end else if (adr_i == REG_STATUS) begin
            st_next.datOut[STAT_SYNC] = st_reg.mfState != MF_SYNC;
            st_next.datOut[STAT_CAS] = st_reg.casAligned;
            st_next.datOut[STAT_NCRC] = st_reg.mfState == MF_NONCRC;
            st_next.datOut[STAT_RAI] = st_reg.raiQ;
            st_next.datOut[STAT_STATE +: 2] = st_reg.mfState;
         end else if (adr_i == REG_ERRCNT) begin
            st_next.datOut[9:0] = st_reg.lastErrCnt;
         end else if (txIdx < CH_COUNT_W) begin
            st_next.datOut[3:0] = st_reg.txSig[txIdx[4:0]];
            if (we_i && sel_i[0]) begin
               st_next.txSig[txIdx[4:0]] = dat_i[3:0];
            end
         end else if (rxIdx < CH_COUNT_W) begin
            st_next.datOut[3:0] = st_reg.rxSig[rxIdx[4:0]];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign dat_o           = st_reg.datOut;
   assign ack_o           = st_reg.ack;
   assign txByte          = st_reg.txByte;
   assign txRai           = st_reg.raiQ;
   assign reframeReq      = st_reg.reframe;
   assign crcErr          = st_reg.crcErr;
   assign crcMfSyncStatus = st_reg.mfState != MF_SYNC;
   assign casMfAligned    = st_reg.casAligned;
   assign nonCrcMode      = st_reg.mfState == MF_NONCRC;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_rai_forced: assert property (st_reg.ctrl[CTRL_RAD] && $stable(st_reg.ctrl)
      |=> txRai == $past(st_reg.ctrl[CTRL_RAF])) else $error("RAI not at force bit");
   a_sync_rai_low: assert property ((st_reg.mfState == MF_SYNC) && !st_reg.ctrl[CTRL_RAD]
      |=> !txRai) else $error("RAI high while in sync");
   a_alarm_rai_high: assert property ((st_reg.mfState == MF_ALARM) && !st_reg.ctrl[CTRL_RAD]
      |=> txRai) else $error("RAI low in alarm state");
   a_fas_pattern: assert property (tsStrobe && (tsNum == TS_ALIGN) && !st_reg.txFrame[0]
      |=> txByte[6:0] == FAS_PATTERN) else $error("Bad FAS pattern");
   a_nfas_marker: assert property (tsStrobe && (tsNum == TS_ALIGN)
      |=> txByte[6] == $past(st_reg.txFrame[0])) else $error("Bad frame type bit");
   a_cas_y_bit: assert property (tsStrobe && (tsNum == TS_SIG) &&
      (st_reg.txCasFrame == FRAME_CAS0) |=> txByte == {CAS_MFAS, SPARE_BIT,
      !$past(st_reg.casAligned), SPARE_BIT, SPARE_BIT}) else $error("Bad CAS frame zero");
   a_ebit_default: assert property (tsStrobe && (tsNum == TS_ALIGN) &&
      (st_reg.txFrame == FRAME_E1) && (st_reg.mfState != MF_SYNC)
      |=> txByte[7] == $past(st_reg.ctrl[CTRL_EDEF])) else $error("E-bit not default");
   a_rem_insert: assert property (tsStrobe && (tsNum == TS_ALIGN) &&
      (st_reg.txFrame == FRAME_CAS0) |=> txByte[7] == $past(st_reg.txRem[3]))
      else $error("Remainder bit C1 wrong");
   a_noncrc_nocheck: assert property ((st_reg.mfState == MF_NONCRC) |-> ##1 !crcErr[*2])
      else $error("CRC check while in non-CRC mode");
   a_ack_single: assert property (ack_o |=> !ack_o) else $error("Ack held two cycles");

   c_sync: cover property ($rose(st_reg.mfState == MF_SYNC));
   c_alarm: cover property ($rose(st_reg.mfState == MF_ALARM));
   c_noncrc: cover property ($rose(st_reg.mfState == MF_NONCRC));
   c_crc_err: cover property (crcErr);
endmodule : e1_crc4_cas_multiframer

// ==== dv/e1_crc4_cas_multiframer_bench.sv ====
// Purpose: Self-checking bench for the E1 CRC-4 and CAS multiframer.
// Assumes: Timers shortened to 40 and 400 cycles.
// Notes:   Registers are reached over classic Wishbone.
`timescale 1ns/1ps
module e1_crc4_cas_multiframer_bench;
   import e1_mf_pkg::*;
   logic        clock, rst_n, cyc, stb, we, ack, tsStrobe, rxAligned, txRai, sync, cas, nonCrc;
   logic [8:0]  adr;
   logic [31:0] wdat, rdat, q;
   logic [4:0]  tsNum;
   logic [7:0]  rxByte, txByte;
   logic        refr;
   int          errCount, nTests, cycCount, refrCount;
   e1_crc4_cas_multiframer #(.reframeCycles(40), .searchCycles(400)) uut (.clock(clock),
      .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
      .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .tsStrobe(tsStrobe), .tsNum(tsNum),
      .txPayload(8'hA5), .rxByte(rxByte), .rxBasicAligned(rxAligned), .txByte(txByte),
      .txRai(txRai), .reframeReq(refr), .crcErr(), .crcMfSyncStatus(sync),
      .casMfAligned(cas), .nonCrcMode(nonCrc));
   e1_far_end farEnd (.clock(clock), .rst_n(rst_n), .tsStrobe(tsStrobe), .tsNum(tsNum),
      .rxByte(rxByte));
   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         errCount++;
      end
   endtask : chk
   task automatic acc(input logic w, input logic [8:0] a, input logic [31:0] d);
      cyc  <= 1'h1;
      stb  <= 1'h1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      @(posedge clock);
      while (ack !== 1'h1) @(posedge clock);
      q = rdat;
      cyc <= 1'h0;
      stb <= 1'h0;
      @(posedge clock);
   endtask : acc
   task automatic waitSlot(input logic [4:0] n);
      @(posedge clock);
      while (!(tsStrobe === 1'h1 && tsNum === n)) @(posedge clock);
      @(posedge clock);
   endtask : waitSlot
   task automatic waitFs(input logic [4:0] n, input logic [3:0] f);
      do waitSlot(n); while (farEnd.frame !== f);
   endtask : waitFs
   task automatic giveVerdict();
      $display("comparisons %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : giveVerdict
   // ----------------------------------------------------------------------
   // Clock, timeout and tests
   // ----------------------------------------------------------------------
   initial begin
      clock = 1'h0;
      forever #12.5 clock = !clock;
   end
   always @(posedge clock) begin
      cycCount++;
      if (refr === 1'h1) refrCount++;
      if (cycCount == 20000) begin
         errCount++;
         giveVerdict();
      end
   end
   initial begin
      {rst_n, cyc, stb, we, rxAligned, adr, wdat} = '0;
      repeat (8) @(posedge clock);
      rst_n <= 1'h1;
      waitSlot(TS_ALIGN);
      chk({25'h0, txByte[6:0]}, 32'h1B);
      waitSlot(TS_SIG);
      chk({24'h0, txByte}, 32'h0F);
      acc(1'h0, REG_CTRL, 32'h0);
      chk(q, 32'h0);
      acc(1'h0, 9'h0FC, 32'h0);
      chk(q, 32'h0);
      $display("test reset done");
      acc(1'h1, REG_CTRL, 32'h8);
      repeat (600) @(posedge clock);
      chk({29'h0, nonCrc, txRai, sync}, 32'h5);
      waitFs(TS_ALIGN, FRAME_E1);
      chk({24'h0, txByte}, 32'hDF);
      acc(1'h1, REG_CTRL, 32'h1);
      repeat (600) @(posedge clock);
      chk({29'h0, nonCrc, txRai, sync}, 32'h3);
      waitFs(TS_ALIGN, FRAME_E1);
      chk({24'h0, txByte}, 32'h7F);
      $display("test search alarm done");
      rxAligned <= 1'h1;
      repeat (4000) @(posedge clock);
      acc(1'h0, REG_STATUS, 32'h0);
      chk(q, 32'h12);
      chk({31'h0, cas}, 32'h1);
      waitFs(TS_SIG, FRAME_CAS0);
      chk({24'h0, txByte}, 32'h0B);
      $display("test alignment done");
      acc(1'h0, 9'h13C, 32'h0);
      chk(q, 32'h1);
      acc(1'h0, 9'h174, 32'h0);
      chk(q, 32'hF);
      acc(1'h1, 9'h044, 32'h9);
      acc(1'h0, 9'h044, 32'h0);
      chk(q, 32'h9);
      waitFs(TS_SIG, 4'h2);
      chk({24'h0, txByte}, 32'h90);
      $display("test signalling done");
      for (int i = 0; i < 2; i++) begin
         acc(1'h1, REG_CTRL, 32'h3 | (i << 2));
         repeat (4) @(posedge clock);
         chk({31'h0, txRai}, i);
      end
      chk(refrCount, 32'h12);
      $display("test forced alarm done");
      giveVerdict();
   end
endmodule : e1_crc4_cas_multiframer_bench

// ==== dv/e1_far_end.sv ====
// Purpose: Far-end E1 terminal that sends framed receive time slots.
// Assumes: One slot every two clocks once reset is released.
// Notes:   Remainder bits are sent as zero, so checks report errors.
`timescale 1ns/1ps
module e1_far_end (
   input  wire logic       clock,
   input  wire logic       rst_n,
   output logic            tsStrobe,
   output logic      [4:0] tsNum,
   output logic      [7:0] rxByte
);
   localparam logic [7:0] MFAS_BITS = 8'hF4;
   logic [3:0] frame;
   logic [3:0] nFr;
   logic [4:0] nTs;
   assign nTs = tsNum + 5'h01;
   assign nFr = (tsNum == 5'h1F) ? frame + 4'h1 : frame;
   always @(posedge clock) begin
      if (!rst_n) begin
         tsStrobe <= 1'h0;
         tsNum    <= 5'h1F;
         frame    <= 4'hF;
         rxByte   <= 8'hFF;
      end else begin
         tsStrobe <= !tsStrobe;
         if (!tsStrobe) begin
            tsNum <= nTs;
            frame <= nFr;
            if (nTs == 5'h00 && !nFr[0]) rxByte <= 8'h1B;
            else if (nTs == 5'h00) rxByte <= {MFAS_BITS[nFr[3:1]], 7'h5F};
            else if (nTs == 5'h10) rxByte <= {nFr, nFr};
            else rxByte <= {3'h0, nTs};
         end
      end
   end
endmodule : e1_far_end

// ==== inc/e1_mf_pkg.sv ====
// Purpose: Shared constants, types and the CRC-4 step for the E1 multiframer.
// Assumes: 40 MHz system clock; frame timing strobes arrive from the basic framer.
// Notes:   Register offsets are byte addresses on a 32-bit classic Wishbone slave.
package e1_mf_pkg;
   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLOCK_HZ       = 40_000_000;
   localparam int CYCLES_PER_MS  = CLOCK_HZ / 1000;
   localparam int REFRAME_MS     = 8;
   localparam int SEARCH_MS      = 400;
   localparam int REFRAME_CYCLES = REFRAME_MS * CYCLES_PER_MS;
   localparam int SEARCH_CYCLES  = SEARCH_MS * CYCLES_PER_MS;
   localparam int TIMER_W        = 24;

   // ----------------------------------------------------------------------
   // Frame structure
   // ----------------------------------------------------------------------
   localparam logic [4:0] TS_ALIGN      = 5'h00;
   localparam logic [4:0] TS_SIG        = 5'h10;
   localparam logic [4:0] TS_LAST       = 5'h1F;
   localparam logic [2:0] SMF_LAST      = 3'h7;
   localparam logic [3:0] FRAME_SMF1END = 4'h7;
   localparam logic [3:0] FRAME_MFAS_END = 4'hB;
   localparam logic [3:0] FRAME_E1      = 4'hD;
   localparam logic [3:0] FRAME_CAS0    = 4'h0;
   localparam logic [6:0] FAS_PATTERN   = 7'h1B;
   localparam logic [5:0] MFAS_PATTERN  = 6'h0B;
   localparam logic [2:0] MFAS_TOP      = 3'h5;
   localparam logic [3:0] CAS_MFAS      = 4'h0;
   localparam logic       SPARE_BIT     = 1'b1;
   localparam logic [4:0] SA_IDLE       = 5'h1F;
   localparam logic [3:0] CRC_POLY      = 4'h3;
   localparam logic [1:0] CBIT_TOP      = 2'h3;
   localparam logic [4:0] SIG_HI_OFS    = 5'h01;
   localparam logic [4:0] SIG_LO_OFS    = 5'h0E;
   localparam int         CH_COUNT      = 30;

   // ----------------------------------------------------------------------
   // Error supervision
   // ----------------------------------------------------------------------
   localparam logic [9:0] CHECKS_PER_SEC = 10'h3E8;
   localparam logic [9:0] ERR_LIMIT      = 10'h392;

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   localparam logic [8:0] REG_CTRL      = 9'h000;
   localparam logic [8:0] REG_STATUS    = 9'h004;
   localparam logic [8:0] REG_ERRCNT    = 9'h008;
   localparam logic [6:0] TXSIG_WORD    = 7'h10;
   localparam logic [6:0] RXSIG_WORD    = 7'h40;
   localparam logic [6:0] CH_COUNT_W    = 7'h1E;
   localparam int CTRL_IWD   = 0;
   localparam int CTRL_RAD   = 1;
   localparam int CTRL_RAF   = 2;
   localparam int CTRL_EDEF  = 3;
   localparam int STAT_SYNC  = 0;
   localparam int STAT_CAS   = 1;
   localparam int STAT_NCRC  = 2;
   localparam int STAT_RAI   = 3;
   localparam int STAT_STATE = 4;

   typedef enum logic [1:0] {
      MF_SEARCH = 2'b00,
      MF_SYNC   = 2'b01,
      MF_ALARM  = 2'b11,
      MF_NONCRC = 2'b10
   } mf_state_t;

   // One CRC-4 step over a byte, MSB first; the shift form includes the X^4 factor.
   function automatic logic [3:0] crc4_byte(input logic [3:0] c, input logic [7:0] d);
      logic [3:0] r;
      logic       fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[3] ^ d[i];
         r  = {r[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
      end
      return r;
   endfunction : crc4_byte
endpackage : e1_mf_pkg
